// >>> rpc_consts.vh
// rpc_consts.vh: constants of the reset and power-on controller.
// assumes a 250 MHz system clock and a low-speed oscillator tick input.
`ifndef RPC_CONSTS_VH
`define RPC_CONSTS_VH

// bus register offsets (byte addresses)
`define RPC_ADR_CAUSE 4'h0
`define RPC_ADR_SRST 4'h4
`define RPC_ADR_WDCLR 4'h8
`define RPC_ADR_IRQST 4'hc
`define RPC_ADR_IRQMSK 4'he
`define RPC_ADR_BANK_HI 1'b1

// watchdog clear key
`define RPC_WD_KEY 8'h5a

// reset vector
`define RPC_RESET_VEC 16'h0000

// timing
`define RPC_CLK_MHZ 250
`define RPC_PWR_STAB_US 4600
`define RPC_DEBOUNCE_US 8000
`define RPC_PWR_STAB_CYC (`RPC_PWR_STAB_US * `RPC_CLK_MHZ)
`define RPC_DEBOUNCE_CYC (`RPC_DEBOUNCE_US * `RPC_CLK_MHZ)
`define RPC_CLK_STAB_CNT 12'h800
`define RPC_LSO_STAB_CNT 3'h4
`define RPC_WD_TICKS 10'h3ff

// cause flag bit positions
`define RPC_CAUSE_LV 7
`define RPC_CAUSE_WD 6
`define RPC_CAUSE_PIN 5
`define RPC_CAUSE_SW 0
`define RPC_CAUSE_POR_INIT 8'h80
`define RPC_CAUSE_SOFT_INIT 8'h01

// watchdog modes
`define RPC_WDM_DIS 2'h0
`define RPC_WDM_EN 2'h1
`define RPC_WDM_ALW 2'h2

// pin modes
`define RPC_PIN_GPIO 2'h0
`define RPC_PIN_RST 2'h1
`define RPC_PIN_RSTDB 2'h2

`endif

// >>> rpc_ctrl.v
// rpc_ctrl.v: reset sources, power-on sequence, watchdog, wishbone regs.
// assumes inputs synchronous to sys_clk_i; low-speed osc as a tick pulse.
`timescale 1ns/10ps
`default_nettype none
`include "rpc_consts.vh"

module rpc_ctrl #(
  parameter PWR_CYC = `RPC_PWR_STAB_CYC,
  parameter DEB_CYC = `RPC_DEBOUNCE_CYC
) (
  // clock and reset
  input wire sys_clk_i,
  input wire nrst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // reset sources and options
  input wire low_voltage_reset_level_i,
  input wire ext_rst_pin_i,
  input wire low_speed_osc_tick_i,
  input wire sel_clk_tick_i,
  input wire cpu_sleep_i,
  input wire [1:0] wd_mode_i,
  input wire [1:0] wd_period_i,
  input wire [1:0] pin_mode_i,
  input wire [2:0] clk_src_sel_i,
  // outputs
  output reg sys_rst_n_o,
  output reg cpu_run_o,
  output reg [15:0] reset_vec_o,
  output reg clk_src_en_o,
  output reg [2:0] clk_src_o,
  output reg irq_o
);

////////////////////////////////////////////////////////////////////////
localparam ST_RST = 2'h0;
localparam ST_PWR = 2'h1;
localparam ST_CLK = 2'h2;
localparam ST_RUN = 2'h3;

function [9:0] wd_prescale;
  input [1:0] sel;
  begin
    wd_prescale = (10'h1 << sel) - 10'h1;
  end
endfunction

// one decoder for the bus write and bank register selects; the read mux uses its own case
function adr_hit;
  input [3:0] adr;
  input [3:0] reg_adr;
  begin
    adr_hit = (adr == reg_adr);
  end
endfunction

reg [1:0] state_r;
reg [31:0] seq_cnt_r;
reg [11:0] clk_cnt_r;
reg [2:0] lso_cnt_r;
reg [31:0] deb_cnt_r;
reg [9:0] wd_cnt_r;
reg [3:0] wd_pre_r;
reg srst_armed_r;
reg [7:0] cause_r;
reg [7:0] cause_nxt;
reg [31:0] rd_dat_nxt;
reg [3:0] irq_st_r;
reg [3:0] irq_msk_r;
reg hard_rst;
reg soft_rst;
reg pin_rst;
reg wd_ovf;

wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
wire hi_bank = adr_hit({wb_adr_i[3:1], 1'b0}, `RPC_ADR_IRQMSK);
wire wr_srst = wb_wr & adr_hit(wb_adr_i, `RPC_ADR_SRST);
wire wr_wd = wb_wr & adr_hit(wb_adr_i, `RPC_ADR_WDCLR);
wire wr_irqst = wb_wr & adr_hit(wb_adr_i, `RPC_ADR_IRQST);
wire wd_clear = wr_wd & (wb_dat_i[7:0] == `RPC_WD_KEY);
wire wd_run = (wd_mode_i == `RPC_WDM_ALW) |
  ((wd_mode_i == `RPC_WDM_EN) & ~cpu_sleep_i);
wire [9:0] wd_limit = wd_prescale(wd_period_i);
wire [3:0] irq_evt = {soft_rst, pin_rst, wd_ovf, low_voltage_reset_level_i};
wire [3:0] irq_clr = wr_irqst ? wb_dat_i[3:0] : 4'h0;
wire [3:0] irq_st_nxt;

////////////////////////////////////////////////////////////////////////
// reset source combination
always @*
begin
  pin_rst = 1'b0;
  if (pin_mode_i == `RPC_PIN_RST)
    pin_rst = ~ext_rst_pin_i;
  else if (pin_mode_i == `RPC_PIN_RSTDB)
    pin_rst = (deb_cnt_r >= DEB_CYC - 1);
  wd_ovf = wd_run & (state_r == ST_RUN) & low_speed_osc_tick_i &
    (wd_pre_r == wd_limit[3:0]) &
    (wd_cnt_r == `RPC_WD_TICKS) & ~wd_clear;
  hard_rst = low_voltage_reset_level_i | pin_rst | wd_ovf;
  soft_rst = wr_srst & wb_dat_i[0] & srst_armed_r;
end

// debounce: a high sample restarts the count
always @(posedge sys_clk_i or negedge nrst_i)
begin
  if (!nrst_i)
    deb_cnt_r <= 32'h0;
  else if (ext_rst_pin_i || pin_mode_i != `RPC_PIN_RSTDB)
    deb_cnt_r <= 32'h0;
  else if (deb_cnt_r < DEB_CYC - 1)
    deb_cnt_r <= deb_cnt_r + 32'h1;
end

////////////////////////////////////////////////////////////////////////
// power-on sequence
always @(posedge sys_clk_i or negedge nrst_i)
begin
  if (!nrst_i)
  begin
    state_r <= ST_RST;
    seq_cnt_r <= 32'h0;
    clk_cnt_r <= 12'h0;
    lso_cnt_r <= 3'h0;
    clk_src_en_o <= 1'b0;
    clk_src_o <= 3'h0;
    cpu_run_o <= 1'b0;
    sys_rst_n_o <= 1'b0;
  end
  else if (hard_rst)
  begin
    state_r <= ST_RST;
    seq_cnt_r <= 32'h0;
    clk_src_en_o <= 1'b0;
    cpu_run_o <= 1'b0;
    sys_rst_n_o <= 1'b0;
  end
  else if (soft_rst)
  begin
    sys_rst_n_o <= 1'b0;
    cpu_run_o <= 1'b0;
  end
  else
  begin
    case (state_r)
      ST_RST:
      begin
        state_r <= ST_PWR;
        seq_cnt_r <= 32'h0;
      end
      ST_PWR:
      begin
        seq_cnt_r <= seq_cnt_r + 32'h1;
        if (seq_cnt_r >= PWR_CYC - 1)
        begin
          state_r <= ST_CLK;
          clk_src_o <= clk_src_sel_i;
          clk_src_en_o <= 1'b1;
          clk_cnt_r <= 12'h0;
          lso_cnt_r <= 3'h0;
        end
      end
      ST_CLK:
      begin
        // both counters saturate; release when both done
        if (sel_clk_tick_i && clk_cnt_r != `RPC_CLK_STAB_CNT)
          clk_cnt_r <= clk_cnt_r + 12'h1;
        if (low_speed_osc_tick_i && lso_cnt_r != `RPC_LSO_STAB_CNT)
          lso_cnt_r <= lso_cnt_r + 3'h1;
        if (clk_cnt_r == `RPC_CLK_STAB_CNT &&
            lso_cnt_r == `RPC_LSO_STAB_CNT)
          state_r <= ST_RUN;
      end
      ST_RUN:
      begin
        sys_rst_n_o <= 1'b1;
        cpu_run_o <= sys_rst_n_o;
      end
      default:
        state_r <= ST_RST;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// watchdog
always @(posedge sys_clk_i or negedge nrst_i)
begin
  if (!nrst_i)
  begin
    wd_cnt_r <= 10'h0;
    wd_pre_r <= 4'h0;
  end
  else if (wd_clear || state_r != ST_RUN || hard_rst)
  begin
    wd_cnt_r <= 10'h0;
    wd_pre_r <= 4'h0;
  end
  else if (wd_run && low_speed_osc_tick_i)
  begin
    if (wd_pre_r == wd_limit[3:0])
    begin
      wd_pre_r <= 4'h0;
      wd_cnt_r <= wd_cnt_r + 10'h1;
    end
    else
      wd_pre_r <= wd_pre_r + 4'h1;
  end
end

////////////////////////////////////////////////////////////////////////
// software reset arm: any other bus write with wb_sel_i[0] set breaks the consecutive pair
always @(posedge sys_clk_i or negedge nrst_i)
begin
  if (!nrst_i)
    srst_armed_r <= 1'b0;
  else if (wr_srst)
    srst_armed_r <= wb_dat_i[0] & ~srst_armed_r;
  else if (wb_wr)
    srst_armed_r <= 1'b0;
end

////////////////////////////////////////////////////////////////////////
// cause flags: only the latest cause is kept
always @*
begin
  cause_nxt = cause_r;
  if (hard_rst)
  begin
    cause_nxt = 8'h0;
    cause_nxt[`RPC_CAUSE_LV] = low_voltage_reset_level_i;
    cause_nxt[`RPC_CAUSE_WD] = wd_ovf & ~low_voltage_reset_level_i;
    cause_nxt[`RPC_CAUSE_PIN] = pin_rst & ~low_voltage_reset_level_i &
      ~wd_ovf;
  end
  else if (soft_rst)
    cause_nxt = `RPC_CAUSE_SOFT_INIT;
end

// power-up counts as a voltage reset
always @(posedge sys_clk_i or negedge nrst_i)
begin
  if (!nrst_i)
    cause_r <= `RPC_CAUSE_POR_INIT;
  else
    cause_r <= cause_nxt;
end

////////////////////////////////////////////////////////////////////////
// interrupt status, one sticky bit per event
genvar gi;
generate
  for (gi = 0; gi < 4; gi = gi + 1)
  begin : g_irq
    // set wins over write-one-to-clear
    assign irq_st_nxt[gi] = (irq_st_r[gi] & ~irq_clr[gi]) | irq_evt[gi];
  end
endgenerate

always @(posedge sys_clk_i or negedge nrst_i)
begin
  if (!nrst_i)
  begin
    irq_st_r <= 4'h0;
    irq_msk_r <= 4'h0;
    irq_o <= 1'b0;
  end
  else
  begin
    irq_st_r <= irq_st_nxt;
    if (wb_wr && hi_bank)
      irq_msk_r <= wb_dat_i[3:0];
    irq_o <= |(irq_st_r & irq_msk_r);
  end
end

////////////////////////////////////////////////////////////////////////
// register read mux; unmapped addresses read zero, except 4'hf, which reads the mask like 4'he
always @*
begin
  rd_dat_nxt = 32'h0;
  if (wb_req && !wb_we_i)
  begin
    if (hi_bank)
      rd_dat_nxt = {28'h0, irq_msk_r};
    else
    begin
      case (wb_adr_i)
        `RPC_ADR_CAUSE: rd_dat_nxt = {24'h0, cause_r};
        `RPC_ADR_SRST: rd_dat_nxt = {31'h0, cause_r[`RPC_CAUSE_SW]};
        `RPC_ADR_IRQST: rd_dat_nxt = {28'h0, irq_st_r};
        default: rd_dat_nxt = 32'h0;
      endcase
    end
  end
end

// ack one cycle after the request, data only beside it
always @(posedge sys_clk_i or negedge nrst_i)
begin
  if (!nrst_i)
  begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h0;
  end
  else
  begin
    wb_ack_o <= wb_req;
    wb_dat_o <= rd_dat_nxt;
  end
end

// fixed vector, kept in a flop so the output is registered
always @(posedge sys_clk_i or negedge nrst_i)
begin
  if (!nrst_i)
    reset_vec_o <= `RPC_RESET_VEC;
  else
    reset_vec_o <= `RPC_RESET_VEC;
end

endmodule // rpc_ctrl
`default_nettype wire

// >>> rpc_ctrl_props.sv
// rpc_ctrl_props.sv: port-level checks of the reset controller.
// assumes one clock domain and the async active-low nrst_i.
`timescale 1ns/10ps
`default_nettype none
module rpc_ctrl_props (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // sources and results
  input wire logic low_voltage_reset_level_i,
  input wire logic ext_rst_pin_i,
  input wire logic [1:0] pin_mode_i,
  input wire logic [2:0] clk_src_sel_i,
  input wire logic sys_rst_n_o,
  input wire logic cpu_run_o,
  input wire logic [15:0] reset_vec_o,
  input wire logic clk_src_en_o,
  input wire logic [2:0] clk_src_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_resp_a: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  vec_zero_a: assert property (reset_vec_o == 16'h0000)
    else $error("bad reset vector");
  run_gate_a: assert property (!sys_rst_n_o |-> !cpu_run_o)
    else $error("cpu runs in reset");
  run_start_a: assert property ($rose(sys_rst_n_o) |=> cpu_run_o)
    else $error("cpu late");
  lv_rst_a: assert property
    (low_voltage_reset_level_i |-> ##[1:2] !sys_rst_n_o)
    else $error("no voltage reset");
  pin_rst_a: assert property
    (pin_mode_i == 2'h1 && !ext_rst_pin_i |-> ##[1:2] !sys_rst_n_o)
    else $error("no pin reset");
  clk_src_a: assert property
    (sys_rst_n_o |-> clk_src_en_o && clk_src_o == clk_src_sel_i)
    else $error("clock source not driven");
  cover property ($rose(cpu_run_o));
  cover property (wb_ack_o);
  cover property ($fell(sys_rst_n_o) && pin_mode_i == 2'h2);
endmodule // rpc_ctrl_props
bind rpc_ctrl rpc_ctrl_props u_props (.sys_clk_i, .nrst_i, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .low_voltage_reset_level_i,
  .ext_rst_pin_i, .pin_mode_i, .clk_src_sel_i, .sys_rst_n_o, .cpu_run_o,
  .reset_vec_o, .clk_src_en_o, .clk_src_o);
`default_nettype wire

// >>> rpc_ctrl_bench.sv
// rpc_ctrl_bench.sv: self-checking bench of the reset controller.
// assumes shortened stabilisation and debounce counts of 20 and 30.
`timescale 1ns/10ps
`default_nettype none
module rpc_ctrl_bench;
  logic sys_clk_i, nrst_i, cyc, stb, we, lv, pin, osc, sck;
  logic [3:0] adr;
  logic [31:0] wdat;
  logic [1:0] wdm, pinm, wdp;
  logic slp;
  wire [15:0] rvec;
  wire csen;
  wire [2:0] csrc;
  wire [31:0] rdat;
  wire ack, srn, run, irq;
  int errors, samples_checked, seed, n;
  logic [31:0] expq[$];
  rpc_ctrl #(.PWR_CYC(20), .DEB_CYC(30)) uut (.sys_clk_i, .nrst_i,
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .low_voltage_reset_level_i(lv), .ext_rst_pin_i(pin),
    .low_speed_osc_tick_i(osc), .sel_clk_tick_i(sck), .cpu_sleep_i(slp),
    .wd_mode_i(wdm), .wd_period_i(wdp), .pin_mode_i(pinm),
    .clk_src_sel_i(3'h5), .sys_rst_n_o(srn), .cpu_run_o(run),
    .reset_vec_o(rvec), .clk_src_en_o(csen), .clk_src_o(csrc),
    .irq_o(irq));
  initial
  begin
    sys_clk_i = 0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    n = 0;
    do @(posedge sys_clk_i); while (ack !== 1'b1 && ++n < 200);
    {cyc, stb} <= 2'b00;
    if (n >= 200)
    begin
      errors++;
      final_report();
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(0, a, 0);
  endtask
  task automatic waitrst(input logic v);
    n = 0;
    while (srn !== v && n < 9000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 9000)
    begin
      errors++;
      final_report();
    end
  endtask
  // random tick pulses keep the stabilisation counts honest
  always @(posedge sys_clk_i)
  begin
    osc <= $random(seed);
    sck <= $random(seed);
    if (ack === 1'b1 && we === 1'b0 && expq.size() > 0)
      chk(rdat, expq.pop_front());
  end
  initial
  begin
    seed = 41;
    {nrst_i, cyc, stb, we, lv, osc, sck, adr, wdat} = 0;
    {pin, wdm, pinm, wdp, slp} = {1'b1, 2'h0, 2'h0, 2'h1, 1'b0};
    repeat (10) @(posedge sys_clk_i);
    nrst_i <= 1;
    waitrst(1);
    rd(4'h0, 32'h80);
    rd(4'h2, 32'h0);
    chk(csen, 1);
    chk(csrc, 3'h5);
    chk(rvec, 16'h0);
    wdm <= 2'h2;
    repeat (8)
    begin
      repeat (300) @(posedge sys_clk_i);
      bus(1, 4'h8, 32'h5a);
    end
    chk(srn, 1);
    waitrst(0);
    wdm <= 2'h0;
    waitrst(1);
    rd(4'h0, 32'h40);
    pinm <= 2'h1;
    pin <= 0;
    waitrst(0);
    pin <= 1;
    waitrst(1);
    rd(4'h0, 32'h20);
    pinm <= 2'h2;
    pin <= 0;
    repeat (10) @(posedge sys_clk_i);
    pin <= 1;
    repeat (40) @(posedge sys_clk_i);
    chk(srn, 1);
    pin <= 0;
    waitrst(0);
    chk(n > 28, 1);
    pin <= 1;
    waitrst(1);
    lv <= 1;
    waitrst(0);
    lv <= 0;
    waitrst(1);
    rd(4'h0, 32'h80);
    bus(1, 4'h4, 32'h1);
    bus(1, 4'h8, 32'h5a);
    bus(1, 4'h4, 32'h1);
    repeat (4) @(posedge sys_clk_i);
    chk(srn, 1);
    bus(1, 4'h4, 32'h1);
    waitrst(0);
    chk(run, 0);
    rd(4'h4, 32'h1);
    bus(1, 4'he, 32'hf);
    rd(4'he, 32'hf);
    chk(irq, 1);
    bus(1, 4'hc, 32'hf);
    rd(4'hc, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    chk(irq, 0);
    final_report();
  end
endmodule // rpc_ctrl_bench
`default_nettype wire
